// [logic/i2c_control_config.sv]
/*
  I2C control/configuration block: control registers 0 and 1,
  digital noise filter on SDA/SCL, interrupt status and mask,
  DMA request gating, slave clock-stretch and general-call decode.
  Assumes an APB master on pclk and a protocol engine on pclk that
  delivers one-cycle event strobes; SDA/SCL arrive from pins.
*/
// Added by the designer: the APB slave port.
// Overview of operation
// RQ1 - Slave stretches SCL unless stretch disabled
// RQ2 - Software keeps stretch-disable zero as master
// RQ3 - Slave byte control active only when set
// RQ4 - DMA requests only with matching enable
// RQ5 - Analog filter bypass; change only disabled
// RQ6 - Digital filter suppresses spikes up to count
// RQ7 - Filter length changed only while disabled
// RQ8 - Error flags interrupt when error enable set
// RQ9 - Transfer-complete interrupt only when enabled
// RQ10 - Stop interrupt only when enabled
// RQ11 - NACK interrupt only when enabled
// RQ12 - Address-match interrupt only when enabled
// RQ13 - Receive interrupt only when enabled
// RQ14 - Transmit interrupt only when enabled
// RQ15 - Hardware clears PEC request on events
// RQ16 - General call answered only when enabled
// RQ17 - General call is address zero
// RQ18 - Interrupt while any enabled flag set
// RQ19 - Reserved bits read zero, writes ignored
`timescale 1ns/100ps

module i2c_control_config
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // I2C pins (sampled asynchronously)
  input wire logic sda_in,
  input wire logic scl_in,
  // Protocol engine events
  input wire i2c_cfg_pkg::evt_t evt,
  // Configuration and control toward the engine
  output i2c_cfg_pkg::cfg_t cfg,
  output logic pec_send_req,
  output logic sda_filt,
  output logic scl_filt,
  output logic scl_hold_low,
  output logic gcall_ack,
  output logic rx_dma_req,
  output logic tx_dma_req,
  // Interrupt
  output logic irq
);

  // ==========================================================
  // Register state
  logic [31:0] ctl0_reg;
  logic pec_reg;
  logic [i2c_cfg_pkg::EV_W-1:0] stat_reg;
  logic [i2c_cfg_pkg::EV_W-1:0] mask_reg;
  logic [i2c_cfg_pkg::EV_W-1:0] stat_next;
  logic [i2c_cfg_pkg::EV_W-1:0] ev_set;
  logic [i2c_cfg_pkg::EV_W-1:0] ev_en;
  logic wr_stb;
  logic rd_stb;
  logic addr_ok;
  logic en;
  logic [3:0] dnf;
  logic gcall_hit;

  assign wr_stb = psel && penable && pwrite;
  assign rd_stb = psel && penable && !pwrite;
  assign addr_ok = (paddr == i2c_cfg_pkg::CTL0_OFFSET)
                || (paddr == i2c_cfg_pkg::CTL1_OFFSET)
                || (paddr == i2c_cfg_pkg::STAT_OFFSET)
                || (paddr == i2c_cfg_pkg::MASK_OFFSET);
  assign en = ctl0_reg[i2c_cfg_pkg::EN_POS];
  assign dnf = ctl0_reg[i2c_cfg_pkg::DNF_LSB +: 4];

  // ==========================================================
  // Control register 0
  // Filter and analog-off fields are frozen while enabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctl0_reg <= i2c_cfg_pkg::CTL0_RESET;
    else if (wr_stb && paddr == i2c_cfg_pkg::CTL0_OFFSET)
    begin
      ctl0_reg <= pwdata & i2c_cfg_pkg::CTL0_WMASK; // RQ19
      if (en)
      begin
        ctl0_reg[i2c_cfg_pkg::DNF_LSB +: 4] <= dnf; // RQ7
        ctl0_reg[i2c_cfg_pkg::AOFF_POS] <=
          ctl0_reg[i2c_cfg_pkg::AOFF_POS]; // RQ5
      end
    end
  end

  // ==========================================================
  // PEC transfer request: software sets, hardware clears
  // Hardware clear wins so a stale request never survives a stop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pec_reg <= 1'b0;
    else if (!en || evt.pec_sent || evt.addr_matched_flag
             || evt.stop_seen_flag)
      pec_reg <= 1'b0; // RQ15
    else if (wr_stb && paddr == i2c_cfg_pkg::CTL1_OFFSET
             && pwdata[i2c_cfg_pkg::PEC_POS])
      pec_reg <= 1'b1;
  end

  // ==========================================================
  // Event collection into sticky status bits
  always_comb
  begin
    ev_set = '0;
    ev_set[i2c_cfg_pkg::EV_RX] = evt.rx_full_flag;
    ev_set[i2c_cfg_pkg::EV_TX] = evt.tx_req_flag;
    ev_set[i2c_cfg_pkg::EV_ADDR] = evt.addr_matched_flag;
    ev_set[i2c_cfg_pkg::EV_NACK] = evt.no_ack_flag;
    ev_set[i2c_cfg_pkg::EV_STOP] = evt.stop_seen_flag;
    ev_set[i2c_cfg_pkg::EV_DONE] = evt.xfer_done_flag;
    ev_set[i2c_cfg_pkg::EV_ERR] = evt.bus_error_flag // RQ8
      | evt.arb_lost_flag | evt.over_under_flag
      | evt.pec_mismatch_flag | evt.timeout_flag | evt.alert_flag;
    ev_set[i2c_cfg_pkg::EV_GCALL] = gcall_hit;
  end

  // Write-one-to-clear; a same-cycle event keeps its bit set
  always_comb
  begin
    stat_next = stat_reg;
    if (wr_stb && paddr == i2c_cfg_pkg::STAT_OFFSET)
      stat_next = stat_next & ~pwdata[i2c_cfg_pkg::EV_W-1:0];
    stat_next = stat_next | ev_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_reg <= i2c_cfg_pkg::STAT_RESET;
    else
      stat_reg <= stat_next;
  end

  // Interrupt mask, same layout as status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_reg <= i2c_cfg_pkg::MASK_RESET;
    else if (wr_stb && paddr == i2c_cfg_pkg::MASK_OFFSET)
      mask_reg <= pwdata[i2c_cfg_pkg::EV_W-1:0];
  end

  // ==========================================================
  // Per-event enables from control register 0
  always_comb
  begin
    ev_en = '0;
    ev_en[i2c_cfg_pkg::EV_RX] = ctl0_reg[i2c_cfg_pkg::RXIE_POS]; // RQ13
    ev_en[i2c_cfg_pkg::EV_TX] = ctl0_reg[i2c_cfg_pkg::TXIE_POS]; // RQ14
    ev_en[i2c_cfg_pkg::EV_ADDR] =
      ctl0_reg[i2c_cfg_pkg::ADDIE_POS]; // RQ12
    ev_en[i2c_cfg_pkg::EV_NACK] =
      ctl0_reg[i2c_cfg_pkg::NO_ACK_IRQ_EN_POS]; // RQ11
    ev_en[i2c_cfg_pkg::EV_STOP] =
      ctl0_reg[i2c_cfg_pkg::STPIE_POS]; // RQ10
    ev_en[i2c_cfg_pkg::EV_DONE] = ctl0_reg[i2c_cfg_pkg::XFER_DONE_IRQ_EN_POS]; // RQ9
    ev_en[i2c_cfg_pkg::EV_ERR] = ctl0_reg[i2c_cfg_pkg::ERROR_IRQ_EN_POS]; // RQ8
    // General call rides on the address-match enable
    ev_en[i2c_cfg_pkg::EV_GCALL] = ctl0_reg[i2c_cfg_pkg::ADDIE_POS];
  end

  // Registered level interrupt from next status, enable and mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(stat_next & ev_en & mask_reg); // RQ18
  end

  // ==========================================================
  // Pin synchronisers and digital noise filter
  logic [1:0] sda_sync;
  logic [1:0] scl_sync;
  logic [3:0] sda_cnt;
  logic [3:0] scl_cnt;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sda_sync <= 2'h3;
      scl_sync <= 2'h3;
    end
    else
    begin
      sda_sync <= {sda_sync[0], sda_in};
      scl_sync <= {scl_sync[0], scl_in};
    end
  end

  // A new level must hold dnf+1 clocks, so spikes of up to dnf clocks are dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sda_filt <= 1'b1;
      sda_cnt <= 4'h0;
    end
    else if (sda_sync[1] == sda_filt)
      sda_cnt <= 4'h0;
    else if (dnf == i2c_cfg_pkg::DNF_ZERO || sda_cnt == dnf) // RQ6
    begin
      sda_filt <= sda_sync[1];
      sda_cnt <= 4'h0;
    end
    else
      sda_cnt <= sda_cnt + 4'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_filt <= 1'b1;
      scl_cnt <= 4'h0;
    end
    else if (scl_sync[1] == scl_filt)
      scl_cnt <= 4'h0;
    else if (dnf == i2c_cfg_pkg::DNF_ZERO || scl_cnt == dnf) // RQ6
    begin
      scl_filt <= scl_sync[1];
      scl_cnt <= 4'h0;
    end
    else
      scl_cnt <= scl_cnt + 4'h1;
  end

  // ==========================================================
  // Slave-side controls: stretch, general call, DMA
  assign gcall_hit = en && evt.addr_valid
    && evt.addr_byte == i2c_cfg_pkg::GCALL_ADDR // RQ17
    && ctl0_reg[i2c_cfg_pkg::GCE_POS]; // RQ16

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_hold_low <= 1'b0;
      gcall_ack <= 1'b0;
      rx_dma_req <= 1'b0;
      tx_dma_req <= 1'b0;
    end
    else
    begin
      scl_hold_low <= en && evt.data_not_ready
        && !ctl0_reg[i2c_cfg_pkg::NOSTR_POS]; // RQ1
      gcall_ack <= gcall_hit;
      rx_dma_req <= en && evt.rx_full_flag
        && ctl0_reg[i2c_cfg_pkg::RXDMA_POS]; // RQ4
      tx_dma_req <= en && evt.tx_req_flag
        && ctl0_reg[i2c_cfg_pkg::TXDMA_POS]; // RQ4
    end
  end

  // Config fields to engine, flopped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg <= '0;
    else
    begin
      cfg.no_stretch <= ctl0_reg[i2c_cfg_pkg::NOSTR_POS];
      cfg.slave_byte_ctrl <= ctl0_reg[i2c_cfg_pkg::SBC_POS]; // RQ3
      cfg.rx_dma_req_en <= ctl0_reg[i2c_cfg_pkg::RXDMA_POS];
      cfg.tx_dma_req_en <= ctl0_reg[i2c_cfg_pkg::TXDMA_POS];
      cfg.analog_filter_off <= ctl0_reg[i2c_cfg_pkg::AOFF_POS]; // RQ5
      cfg.general_call_en <= ctl0_reg[i2c_cfg_pkg::GCE_POS];
      cfg.periph_enable <= en;
    end
  end

  assign pec_send_req = pec_reg;

  // ==========================================================
  // APB answer: zero wait states, error on unmapped address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite)
        unique case (paddr)
          i2c_cfg_pkg::CTL0_OFFSET: prdata <= ctl0_reg;
          i2c_cfg_pkg::CTL1_OFFSET:
            prdata <= {5'h00, pec_reg, 26'h0000000};
          i2c_cfg_pkg::STAT_OFFSET: prdata <= {24'h000000, stat_reg};
          i2c_cfg_pkg::MASK_OFFSET: prdata <= {24'h000000, mask_reg};
          default: prdata <= 32'h00000000;
        endcase
    end
  end

endmodule

// [common/i2c_cfg_pkg.sv]
/*
  Package for the I2C configuration and interrupt-enable block.
  Holds register offsets, field positions, reset values and the
  packed structs that carry control fields and engine events.
  Assumes a 32-bit APB bus with word-aligned registers.
*/
package i2c_cfg_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] CTL0_OFFSET = 8'h00;
  localparam logic [7:0] CTL1_OFFSET = 8'h04;
  localparam logic [7:0] STAT_OFFSET = 8'h08;
  localparam logic [7:0] MASK_OFFSET = 8'h0C;

  // ==========================================================
  // Control register 0 field positions
  localparam int SBC_POS = 16;
  localparam int NOSTR_POS = 17;
  localparam int GCE_POS = 19;
  localparam int RXDMA_POS = 15;
  localparam int TXDMA_POS = 14;
  localparam int AOFF_POS = 12;
  localparam int DNF_LSB = 8;
  localparam int ERROR_IRQ_EN_POS = 7;
  localparam int XFER_DONE_IRQ_EN_POS = 6;
  localparam int STPIE_POS = 5;
  localparam int NO_ACK_IRQ_EN_POS = 4;
  localparam int ADDIE_POS = 3;
  localparam int RXIE_POS = 2;
  localparam int TXIE_POS = 1;
  localparam int EN_POS = 0;
  // Writable bits of control register 0; the rest read as zero
  localparam logic [31:0] CTL0_WMASK = 32'h000BDFFF;
  localparam logic [31:0] CTL0_RESET = 32'h00000000;

  // Control register 1: only the PEC request bit lives here
  localparam int PEC_POS = 26;
  localparam logic [31:0] CTL1_RESET = 32'h00000000;

  // ==========================================================
  // Status / mask layout (sticky event bits)
  localparam int EV_RX = 0;
  localparam int EV_TX = 1;
  localparam int EV_ADDR = 2;
  localparam int EV_NACK = 3;
  localparam int EV_STOP = 4;
  localparam int EV_DONE = 5;
  localparam int EV_ERR = 6;
  localparam int EV_GCALL = 7;
  localparam int EV_W = 8;
  localparam logic [EV_W-1:0] STAT_RESET = 8'h00;
  localparam logic [EV_W-1:0] MASK_RESET = 8'h00;

  // General call address byte
  localparam logic [6:0] GCALL_ADDR = 7'h00;
  localparam logic [3:0] DNF_ZERO = 4'h0;

  // ==========================================================
  // Control fields handed to the protocol engine
  typedef struct packed {
    logic no_stretch;
    logic slave_byte_ctrl;
    logic rx_dma_req_en;
    logic tx_dma_req_en;
    logic analog_filter_off;
    logic general_call_en;
    logic periph_enable;
  } cfg_t;

  // Engine event strobes, one cycle each
  typedef struct packed {
    logic rx_full_flag;
    logic tx_req_flag;
    logic addr_matched_flag;
    logic no_ack_flag;
    logic stop_seen_flag;
    logic xfer_done_flag;
    logic bus_error_flag;
    logic arb_lost_flag;
    logic over_under_flag;
    logic pec_mismatch_flag;
    logic timeout_flag;
    logic alert_flag;
    logic pec_sent;
    logic data_not_ready;
    logic addr_valid;
    logic [6:0] addr_byte;
  } evt_t;

endpackage

// [testbench/i2c_cfg_monitor.sv]
/* Checker on the I2C control block ports.
   Assumes the bind below and the single pclk domain. */
`timescale 1ns/100ps
module i2c_cfg_monitor
(
  // Clock, reset, APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Engine side
  input wire i2c_cfg_pkg::evt_t evt,
  input wire i2c_cfg_pkg::cfg_t cfg,
  input wire logic pec_send_req,
  input wire logic scl_hold_low,
  input wire logic gcall_ack,
  input wire logic rx_dma_req,
  input wire logic tx_dma_req
);
  // =====
  // cfg trails ctl0 by one cycle, as the registered outputs do
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  property p_ready; s_setup |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready missing");
  property p_once; pready |-> $past(psel && !penable); endproperty
  a_once: assert property (p_once) else $error("stray pready");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr alone");
  property p_nostr; cfg.no_stretch |-> !scl_hold_low; endproperty
  a_nostr: assert property (p_nostr) else $error("stretch");
  property p_str; $past(evt.data_not_ready) && cfg.periph_enable
    && !cfg.no_stretch |-> scl_hold_low; endproperty
  a_str: assert property (p_str) else $error("no stretch");
  property p_rxdma; rx_dma_req |-> $past(evt.rx_full_flag)
    && cfg.rx_dma_req_en && cfg.periph_enable; endproperty
  a_rxdma: assert property (p_rxdma) else $error("rx dma");
  property p_txdma; tx_dma_req |-> $past(evt.tx_req_flag)
    && cfg.tx_dma_req_en && cfg.periph_enable; endproperty
  a_txdma: assert property (p_txdma) else $error("tx dma");
  property p_gcall; gcall_ack |-> $past(evt.addr_valid) && cfg.general_call_en
    && $past(evt.addr_byte) == i2c_cfg_pkg::GCALL_ADDR; endproperty
  a_gcall: assert property (p_gcall) else $error("gcall");
  property p_pec; pec_send_req |-> cfg.periph_enable && !$past(evt.pec_sent
    || evt.stop_seen_flag || evt.addr_matched_flag); endproperty
  a_pec: assert property (p_pec) else $error("pec kept");
endmodule
bind i2c_control_config i2c_cfg_monitor u_mon (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .evt(evt), .cfg(cfg), .pec_send_req(pec_send_req),
  .scl_hold_low(scl_hold_low), .gcall_ack(gcall_ack),
  .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req));

// [testbench/i2c_bus_agent.sv]
/* Far-side I2C agent driving the pin inputs.
   Assumes pull-ups: idle high, SCL runs only in frames. */
`timescale 1ns/100ps
module i2c_bus_agent
(
  // Bus lines
  output logic scl,
  output logic sda
);
  // Released lines sit at the pull-up level
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Low spike on SCL
  task glitch(input int ns);
    scl = 1'b0;
    #(ns);
    scl = 1'b1;
  endtask
  // Start, eight bits at 320 ns, released ack, stop
  task frame(input logic [7:0] b);
    sda = 1'b0;
    for (int i = 8; i >= 0; i--)
    begin
      #160 scl = 1'b0;
      #80 sda = (i > 0) ? b[i - 1] : 1'b1;
      #80 scl = 1'b1;
    end
    #160 scl = 1'b0;
    #80 sda = 1'b0;
    #80 scl = 1'b1;
    #80 sda = 1'b1;
  endtask
endmodule

// [testbench/test_i2c_control_config.sv]
/* Bench for the I2C control block: APB tasks, engine strobes,
   far-side agent on the pins. Assumes the bound checker. */
`timescale 1ns/100ps
module test_i2c_control_config;
  // =====
  // Signals
  logic pclk, presetn, psel, penable, pwrite, sda_in, scl_in, re;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic pready, pslverr, sda_filt, scl_filt, scl_hold_low, irq;
  logic pec_send_req, gcall_ack, rx_dma_req, tx_dma_req;
  i2c_cfg_pkg::evt_t evt;
  i2c_cfg_pkg::cfg_t cfg;
  int fails, total_checks;
  int epos [0:6] = '{2, 1, 3, 4, 5, 6, 7};
  // Block and agent
  i2c_control_config u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sda_in(sda_in),
    .scl_in(scl_in), .evt(evt), .cfg(cfg), .pec_send_req(pec_send_req),
    .sda_filt(sda_filt), .scl_filt(scl_filt), .scl_hold_low(scl_hold_low),
    .gcall_ack(gcall_ack), .rx_dma_req(rx_dma_req),
    .tx_dma_req(tx_dma_req), .irq(irq));
  i2c_bus_agent u_agent (.scl(scl_in), .sda(sda_in));
  // 25 MHz clock
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;
  // =====
  // Compare, verdict, bus tasks
  task chk(input string n, input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      $display("MISMATCH %s exp %h got %h", n, e, g);
      fails++;
    end
  endtask
  task print_verdict();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Held until pready; only the watchdog ends a hung wait
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Disable first: filter fields only change while off
  task ctl(input logic [31:0] c);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h00, c);
  endtask
  task pulse(input logic [21:0] v);
    evt <= i2c_cfg_pkg::evt_t'(v);
    @(posedge pclk);
    evt <= '0;
  endtask
  // =====
  // Scenarios
  task t_regs();
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reset", {rq[30:0], re}, {31'h0, i == 4});
    end
    apb(1'b1, 8'h00, 32'hFFFFFFFF);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctl0", rq, 32'h000BDFFF);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk("locked", rq, 32'h00001F00);
  endtask
  task irq_case(input int k, input logic [31:0] c, input logic [7:0] m,
    input logic x);
    ctl(c);
    apb(1'b1, 8'h0C, {24'h0, m});
    pulse(22'h200000 >> k);
    repeat (2) @(posedge pclk);
    chk("irq", 32'(irq), 32'(x));
    apb(1'b0, 8'h08, 32'h0);
    chk("stat", rq, 32'h1 << ((k < 6) ? k : 6));
    apb(1'b1, 8'h08, 32'hFF);
    @(posedge pclk);
    chk("irq off", 32'(irq), 32'h0);
  endtask
  task t_irq();
    logic [31:0] e;
    for (int k = 0; k < 12; k++)
    begin
      e = 32'h1 | (32'h1 << epos[(k < 6) ? k : 6]);
      irq_case(k, 32'h1, 8'hFF, 1'b0);
      irq_case(k, e, 8'h00, 1'b0);
      irq_case(k, e, 8'hFF, 1'b1);
    end
  endtask
  task p_case(input logic [31:0] c, input logic [21:0] v, input int o,
    input int x);
    int n;
    n = 0;
    ctl(c);
    pulse(v);
    repeat (3)
    begin
      @(posedge pclk);
      n += ({gcall_ack, tx_dma_req, rx_dma_req} >> o) & 3'h1;
    end
    chk("pulses", 32'(n), 32'(x));
  endtask
  task t_pulse();
    p_case(32'h00001, 22'h200000, 0, 0);
    p_case(32'h08001, 22'h200000, 0, 1);
    p_case(32'h08001, 22'h100000, 1, 0);
    p_case(32'h04001, 22'h100000, 1, 1);
    p_case(32'h80001, 22'h000080, 2, 1);
    p_case(32'h80001, 22'h0000A1, 2, 0);
    p_case(32'h00001, 22'h000080, 2, 0);
  endtask
  task t_stretch(input logic [31:0] c, input logic x);
    ctl(c);
    evt <= i2c_cfg_pkg::evt_t'(22'h100);
    repeat (3) @(posedge pclk);
    chk("hold", 32'(scl_hold_low), 32'(x));
    chk("cfg", 32'(cfg[5]), 32'(c[16]));
    evt <= '0;
    @(posedge pclk);
  endtask
  // Code 99 stands for disabling the block
  task t_pec(input int k);
    ctl(32'h1);
    apb(1'b1, 8'h04, 32'h04000000);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk("pec set", rq, 32'h04000000);
    chk("pec out", 32'(pec_send_req), 32'h1);
    if (k == 99)
      ctl(32'h0);
    else
      pulse(22'h200000 >> k);
    apb(1'b0, 8'h04, 32'h0);
    chk("pec clr", rq, 32'h0);
    chk("pec out off", 32'(pec_send_req), 32'h0);
  endtask
  // A zero spike length sends a whole frame instead
  task t_filt(input logic [31:0] c, input int ns, input logic x);
    int ls, ld;
    ls = 0;
    ld = 0;
    ctl(c);
    fork
      #10 if (ns > 0) u_agent.glitch(ns); else u_agent.frame(8'h00);
      repeat (110)
      begin
        @(posedge pclk);
        ls += !scl_filt;
        ld += !sda_filt;
      end
    join
    chk("scl", 32'(ls > 0), 32'(x));
    chk("sda", {ld > 0, scl_filt, sda_filt}, {ns == 0, 2'h3});
    chk("aoff", 32'(cfg[2]), 32'(c[12]));
  endtask
  // =====
  // Main sequence and watchdog
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    evt = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_irq();
    t_pulse();
    t_stretch(32'h00001, 1'b1);
    t_stretch(32'h30001, 1'b0);
    t_pec(12);
    t_pec(2);
    t_pec(4);
    t_pec(99);
    t_filt(32'h201, 80, 1'b0);
    t_filt(32'h001, 80, 1'b1);
    t_filt(32'h1201, 0, 1'b1);
    print_verdict();
  end
  initial
  begin
    #2000000;
    fails++;
    print_verdict();
  end
endmodule
